/* File: dsw_cmp_if.sv */
// Purpose: carries monitor measurements to the comparator module
// Assumes: unsigned magnitudes of width MW, thermal timers 8 bits
// Notes: compare results return on the same interface
`timescale 1ns/1ps
interface dsw_cmp_if #(parameter int MW = 16);
	logic [MW-1:0] speed_act;
	logic [MW-1:0] speed_ref;
	logic [MW-1:0] out_freq;
	logic [MW-1:0] freq_lo;
	logic [MW-1:0] freq_hi;
	logic [MW-1:0] torque;
	logic [MW-1:0] torq_lim_mot;
	logic [MW-1:0] torq_lim_gen;
	logic [7:0] motor_timer;
	logic [7:0] drive_timer;
	logic at_ref;
	logic freq_ok;
	logic freq_nz;
	logic torq_exc;
	logic timer_exc;
	modport top (output speed_act, speed_ref, out_freq, freq_lo, freq_hi, torque,
		torq_lim_mot, torq_lim_gen, motor_timer, drive_timer,
		input at_ref, freq_ok, freq_nz, torq_exc, timer_exc);
	modport cmp (input speed_act, speed_ref, out_freq, freq_lo, freq_hi, torque,
		torq_lim_mot, torq_lim_gen, motor_timer, drive_timer,
		output at_ref, freq_ok, freq_nz, torq_exc, timer_exc);
endinterface // dsw_cmp_if

/* File: dsw_compare.sv */
// Purpose: magnitude comparisons feeding the status word
// Assumes: all quantities unsigned
// Notes: purely combinational
`timescale 1ns/1ps
module dsw_compare
	import dsw_pkg::*;
(
	dsw_cmp_if.cmp c // measurements in, results out
);
	// over-limit test, shared by torque and timers
	function automatic logic over(input logic [31:0] v, input logic [31:0] lim);
		return v > lim;
	endfunction

	// speed match, frequency window, motion
	assign c.at_ref = (c.speed_act == c.speed_ref);
	assign c.freq_ok = (c.out_freq >= c.freq_lo) && (c.out_freq <= c.freq_hi);
	assign c.freq_nz = |c.out_freq;
	// either torque limit exceeded
	assign c.torq_exc = over(32'(c.torque), 32'(c.torq_lim_mot))
		|| over(32'(c.torque), 32'(c.torq_lim_gen));
	// either thermal timer above full scale
	assign c.timer_exc = over(32'(c.motor_timer), 32'(TIMER_FULL))
		|| over(32'(c.drive_timer), 32'(TIMER_FULL));
endmodule // dsw_compare

/* File: dsw_master_model.sv */
// Purpose: fieldbus master that writes commands and reads the status word
// Assumes: one command per clock, driven by the bench
// Notes: behavioural, no telegram framing
`timescale 1ns/1ps
module dsw_master_model (
	input wire logic clk, // controller clock
	input wire logic [15:0] cmd_in, // command the bench wants sent
	input wire logic go_start, // send the start release pattern
	input wire logic [15:0] status_in, // status word from the drive
	output logic [15:0] cmd_out, // command word to the drive
	output logic [15:0] status_seen // last status word read
);
	// release: off1 with both stops and valid set
	always_comb cmd_out = go_start ? 16'h0406 : cmd_in;
	// cyclic read, as a telegram would fetch it
	always_ff @(posedge clk) status_seen <= status_in;
endmodule // dsw_master_model

/* File: dsw_pkg.sv */
// Purpose: constants for the drive status word builder
// Assumes: one 16-bit status word, command word of the same width
// Notes: bit positions of status and command words
package dsw_pkg;
	localparam int WORD_W = 16;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	// command word bit positions
	localparam int CMD_ON1 = 0;
	localparam int CMD_ON2 = 1;
	localparam int CMD_ON3 = 2;
	localparam int CMD_RESET = 7;
	localparam int CMD_VALID = 10;
	// status word bit positions
	localparam int ST_CTRL_RDY = 0;
	localparam int ST_DRV_RDY = 1;
	localparam int ST_ENABLE = 2;
	localparam int ST_TRIP = 3;
	localparam int ST_ON2 = 4;
	localparam int ST_ON3 = 5;
	localparam int ST_NO_START = 6;
	localparam int ST_WARN = 7;
	localparam int ST_AT_REF = 8;
	localparam int ST_BUS_CTRL = 9;
	localparam int ST_FREQ_OK = 10;
	localparam int ST_RUNNING = 11;
	localparam int ST_OVL_STOP = 12;
	localparam int ST_VOLT_EXC = 13;
	localparam int ST_TORQ_EXC = 14;
	localparam int ST_TIMER_EXC = 15;
	// thermal timer full scale, 100 percent
	localparam logic [7:0] TIMER_FULL = 8'h64;
	// reference site codes
	localparam logic [1:0] SITE_LOCAL = 2'h0;
	localparam logic [1:0] SITE_LINKED = 2'h2;
	// start inhibit states
	typedef enum logic [0:0] {
		INH_FREE = 1'b0,
		INH_SET = 1'b1
	} dsw_inh_t;
endpackage

/* File: dsw_status_builder.sv */
// Purpose: assembles the drive status word reported to the fieldbus master
// Assumes: all inputs except the async resetn synchronous to clk, 50 MHz
// Notes: the word is read directly from drive_status_word
// How it works
// - bit 2 enable: stops all released, no trip
// - bit 3 trip, hold start until reset
// - bit 4 copies coast-stop command bit
// - bit 5 copies quick-stop command bit
// - bit 6 set after stop, ack, power-up
// - bit 6 cleared by off1, on2, on3, valid
// - bit 7 follows any active warning
// - bit 8 set when speed equals reference
// - bit 9 clear for local stop or site
// - bit 10 frequency within warning limits
// - bit 11 start signal or nonzero frequency
// - bit 12 overload halt without trip
// - bit 13 dc voltage out of limits
// - bit 14 either torque limit exceeded
// - bit 15 either thermal timer over full
// - bit 0 control ready: stops released, no trip
// - bit 1 as bit 0 plus power supplied
`timescale 1ns/1ps
module dsw_status_builder
	import dsw_pkg::*;
#(
	parameter int MW = 16 // measurement width
) (
	input wire logic clk, // controller clock
	input wire logic resetn, // async reset, active low
	input wire logic [15:0] drive_command_word, // command word from master
	input wire logic profile_sel, // standard drive profile selected
	input wire logic fault_event, // drive fault occurred
	input wire logic switch_off_ack, // switch-off acknowledge pulse
	input wire logic warning_any, // any warning active
	input wire logic panel_stop, // stopped by local_operator_panel key
	input wire logic [1:0] ref_site, // reference site setting
	input wire logic start_signal, // start command present
	input wire logic overload_halt, // temporary overload halt
	input wire logic power_ok, // power unit supplied
	input wire logic dc_low, // dc link under voltage
	input wire logic dc_high, // dc link over voltage
	input wire logic [MW-1:0] speed_act, // actual speed
	input wire logic [MW-1:0] speed_ref, // speed reference
	input wire logic [MW-1:0] out_freq, // output frequency
	input wire logic [MW-1:0] freq_lo, // low warning limit
	input wire logic [MW-1:0] freq_hi, // high warning limit
	input wire logic [MW-1:0] torque, // motor torque magnitude
	input wire logic [MW-1:0] torq_lim_mot, // motoring torque limit
	input wire logic [MW-1:0] torq_lim_gen, // generating torque limit
	input wire logic [7:0] motor_timer, // motor thermal timer, percent
	input wire logic [7:0] drive_timer, // drive thermal timer, percent
	output logic [15:0] drive_status_word, // registered status word
	output logic start_blocked // trip holds start off
);
	// comparator works on 32-bit operands, so wider measurements are refused
	if (MW < 1 || MW > 32) begin : g_bad_mw
		$error("dsw_status_builder: MW must be 1..32");
	end

	dsw_cmp_if #(.MW(MW)) cmp_bus ();

	logic trip_q, trip_d;
	logic rst_cmd_q, rst_cmd_d;
	logic off_prev_q, off_prev_d;
	dsw_inh_t inh_q, inh_d;
	logic [15:0] word_q, word_d;
	logic stops_ok, cmd_on2, cmd_on3;
	logic rst_rise, off_event, inh_release;

	// measurements to comparator
	assign cmp_bus.speed_act = speed_act;
	assign cmp_bus.speed_ref = speed_ref;
	assign cmp_bus.out_freq = out_freq;
	assign cmp_bus.freq_lo = freq_lo;
	assign cmp_bus.freq_hi = freq_hi;
	assign cmp_bus.torque = torque;
	assign cmp_bus.torq_lim_mot = torq_lim_mot;
	assign cmp_bus.torq_lim_gen = torq_lim_gen;
	assign cmp_bus.motor_timer = motor_timer;
	assign cmp_bus.drive_timer = drive_timer;

	dsw_compare u_cmp (
		.c(cmp_bus)
	);

	// command decode
	assign cmd_on2 = drive_command_word[CMD_ON2];
	assign cmd_on3 = drive_command_word[CMD_ON3];
	assign stops_ok = drive_command_word[CMD_ON1] & cmd_on2 & cmd_on3;
	assign rst_rise = drive_command_word[CMD_RESET] & ~rst_cmd_q;
	// coast_stop_activation/quick_stop_activation activation: a falling stop bit, edge-detected against the previous cycle
	assign off_event = off_prev_q & ~(cmd_on2 & cmd_on3);
	assign inh_release = ~drive_command_word[CMD_ON1] & cmd_on2 & cmd_on3
		& drive_command_word[CMD_VALID];

	// trip latch and start inhibit next state
	always_comb begin
		trip_d = trip_q;
		rst_cmd_d = drive_command_word[CMD_RESET];
		off_prev_d = cmd_on2 & cmd_on3;
		inh_d = inh_q;
		// trip held until reset; new fault wins over reset
		if (fault_event)
			trip_d = 1'b1;
		else if (rst_rise)
			trip_d = 1'b0;
		if (profile_sel && (switch_off_ack || off_event))
			inh_d = INH_SET;
		else if (inh_release)
			inh_d = INH_FREE;
	end

	// status word assembly
	always_comb begin
		word_d = STATUS_RESET;
		word_d[ST_CTRL_RDY] = stops_ok & ~trip_q;
		word_d[ST_DRV_RDY] = stops_ok & ~trip_q & power_ok;
		word_d[ST_ENABLE] = stops_ok & ~trip_q;
		word_d[ST_TRIP] = trip_q;
		word_d[ST_ON2] = cmd_on2;
		word_d[ST_ON3] = cmd_on3;
		word_d[ST_NO_START] = profile_sel & (inh_q == INH_SET);
		word_d[ST_WARN] = warning_any;
		word_d[ST_AT_REF] = cmp_bus.at_ref;
		word_d[ST_BUS_CTRL] = ~panel_stop & (ref_site != SITE_LOCAL)
			& (ref_site != SITE_LINKED);
		word_d[ST_FREQ_OK] = cmp_bus.freq_ok;
		word_d[ST_RUNNING] = start_signal | cmp_bus.freq_nz;
		word_d[ST_OVL_STOP] = overload_halt & ~trip_q;
		word_d[ST_VOLT_EXC] = dc_low | dc_high;
		word_d[ST_TORQ_EXC] = cmp_bus.torq_exc;
		word_d[ST_TIMER_EXC] = cmp_bus.timer_exc;
	end

	// one register for whole word
	// inhibit powers up set: mains switch-on blocks start
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			word_q <= STATUS_RESET;
			trip_q <= 1'b0;
			rst_cmd_q <= 1'b0;
			off_prev_q <= 1'b0;
			inh_q <= INH_SET;
		end else begin
			word_q <= word_d;
			trip_q <= trip_d;
			rst_cmd_q <= rst_cmd_d;
			off_prev_q <= off_prev_d;
			inh_q <= inh_d;
		end
	end

	assign drive_status_word = word_q;
	assign start_blocked = trip_q;
endmodule // dsw_status_builder

/* File: dsw_status_builder_assertions.sv */
// Purpose: port checks of the status word builder
// Assumes: single clock, async active-low reset
// Notes: direct bits lag their inputs by one edge
`timescale 1ns/1ps
module dsw_status_builder_assertions (
	input wire logic clk, // controller clock
	input wire logic resetn, // async reset, active low
	input wire logic [15:0] drive_command_word, // command word
	input wire logic fault_event, // fault input
	input wire logic warning_any, // warning input
	input wire logic panel_stop, // panel stop input
	input wire logic dc_low, // dc under voltage
	input wire logic dc_high, // dc over voltage
	input wire logic [15:0] drive_status_word, // status word
	input wire logic start_blocked // trip flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// past guard skips the first edge after release
	a_coast_copy: assert property ($past(resetn) |-> drive_status_word[4] == $past(drive_command_word[1]))
		else $error("coast stop bit wrong");
	a_quick_copy: assert property ($past(resetn) |-> drive_status_word[5] == $past(drive_command_word[2]))
		else $error("quick stop bit wrong");
	a_warn_follow: assert property ($past(resetn) |-> drive_status_word[7] == $past(warning_any))
		else $error("warning bit wrong");
	a_volt_flag: assert property ($past(resetn) |-> drive_status_word[13] == $past(dc_low | dc_high))
		else $error("voltage bit wrong");
	a_trip_shown: assert property (fault_event |-> ##1 start_blocked ##1 drive_status_word[3])
		else $error("trip not shown");
	a_enable_stops: assert property ($past(resetn) && !(&$past(drive_command_word[2:0])) |-> !drive_status_word[2])
		else $error("enable with stop active");
	a_ctrl_ready: assert property ($past(resetn) && !(&$past(drive_command_word[2:0])) |-> !drive_status_word[0])
		else $error("ready with stop active");
	a_drive_ready: assert property (drive_status_word[1] |-> drive_status_word[0])
		else $error("drive ready without control ready");
	a_panel_local: assert property ($past(resetn) && $past(panel_stop) |-> !drive_status_word[9])
		else $error("bus control during panel stop");
	c_fault: cover property (fault_event);
	c_no_start: cover property (drive_status_word[6]);
	c_at_ref: cover property (drive_status_word[8]);
endmodule // dsw_status_builder_assertions
bind dsw_status_builder dsw_status_builder_assertions u_chk (.clk, .resetn, .drive_command_word,
	.fault_event, .warning_any, .panel_stop, .dc_low, .dc_high, .drive_status_word, .start_blocked);

/* File: dsw_status_builder_tb.sv */
// Purpose: self-checking bench of the status word builder
// Assumes: inputs driven on the falling edge
// Notes: random phase checks the direct bits, then directed trip and inhibit
`timescale 1ns/1ps
module dsw_status_builder_tb;
	import dsw_pkg::*;
	logic clk, resetn, go_start, prof, flt, ack, warn, pstop, start, ovl, pwr, dl, dh, blk;
	logic [1:0] site;
	logic [7:0] sa, sr, f, lo, hi, tq, tm, tg, mt, dt;
	logic [15:0] cmd_in, cmd, word, seen, r, ex;
	logic [31:0] e;
	logic [31:0] expq[$];
	int num_errors, n_tests;
	dsw_master_model M (.clk(clk), .cmd_in(cmd_in), .go_start(go_start), .status_in(word),
		.cmd_out(cmd), .status_seen(seen));
	dsw_status_builder #(.MW(8)) DUT (.clk(clk), .resetn(resetn), .drive_command_word(cmd),
		.profile_sel(prof), .fault_event(flt), .switch_off_ack(ack), .warning_any(warn),
		.panel_stop(pstop), .ref_site(site), .start_signal(start), .overload_halt(ovl),
		.power_ok(pwr), .dc_low(dl), .dc_high(dh), .speed_act(sa), .speed_ref(sr),
		.out_freq(f), .freq_lo(lo), .freq_hi(hi), .torque(tq), .torq_lim_mot(tm),
		.torq_lim_gen(tg), .motor_timer(mt), .drive_timer(dt), .drive_status_word(word),
		.start_blocked(blk));
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic cmp(input string nm, input logic [15:0] xp, input logic [15:0] s);
		n_tests++;
		if (s !== xp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, xp, s);
		end
	endtask
	task automatic end_sim;
		$display("errors %0d comparisons %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// one random cycle; bit 6 expected low since profile is off
	task automatic step;
		@(negedge clk);
		r = lfsr(r); cmd_in = r; {warn, pstop, site, start, dl, dh, ovl, pwr, ack} = r[15:6];
		r = lfsr(r); {sa, lo} = r;
		r = lfsr(r); {f, hi} = r;
		r = lfsr(r); {tq, tm} = r; sr = r[0] ? sa : r[15:8];
		r = lfsr(r); {tg, mt} = r; dt = r[7:0] ^ r[15:8];
		ex = {mt > TIMER_FULL || dt > TIMER_FULL, tq > tm || tq > tg, dl | dh, ovl,
			start | (f != 8'h00), f >= lo && f <= hi, !(pstop || site == SITE_LOCAL ||
			site == SITE_LINKED), sa == sr, warn, 1'b0, cmd_in[2], cmd_in[1], 4'h0};
		expq.push_back({16'hfff0, ex});
	endtask
	// watcher: result lands on the edge after the inputs were driven
	always @(posedge clk) if (expq.size() > 0) begin
		#1 e = expq.pop_front();
		cmp("word", e[15:0], word & e[31:16]);
	end
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#40000 num_errors++;
		end_sim;
	end
	initial begin
		{resetn, go_start, prof, flt, ack, warn, pstop, start, ovl, pwr, dl, dh, site} = '0;
		{sa, sr, f, lo, hi, tq, tm, tg, mt, dt} = '0;
		{cmd_in, num_errors, n_tests} = '0;
		r = 16'h6a59;
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		repeat (300) step();
		@(negedge clk) {ack, ovl, pwr} = 3'h1; cmd_in = 16'h0407; flt = 1'b1;
		@(negedge clk) flt = 1'b0;
		cmp("blocked", 16'h0001, {15'h0000, blk});
		@(negedge clk) cmp("trip", 16'h0008, word & 16'h000f);
		cmd_in = 16'h0487;
		repeat (2) @(negedge clk);
		cmp("ready", 16'h0007, word & 16'h000f);
		// start inhibit: ack sets, release pattern clears, coast stop sets
		prof = 1'b1; ack = 1'b1;
		@(negedge clk) ack = 1'b0;
		@(negedge clk) cmp("ack inhibit", 16'h0040, word & 16'h0040);
		go_start = 1'b1;
		// release edge, word edge, then one more for the master's read
		repeat (3) @(negedge clk);
		cmp("released", 16'h0000, seen & 16'h0040);
		go_start = 1'b0; cmd_in = 16'h0405;
		repeat (3) @(negedge clk);
		cmp("coast inhibit", 16'h0040, word & 16'h0040);
		end_sim;
	end
endmodule // dsw_status_builder_tb
